// >>> logic/fspe_consts.vh
// Constants for the flash segment program and erase sequencer
`ifndef FSPE_CONSTS_VH
`define FSPE_CONSTS_VH
// -----------------------------------------------------------------
// Geometry
// -----------------------------------------------------------------
`define FSPE_MAIN_SEG_BYTES 512
`define FSPE_INFO_SEG_BYTES 64
`define FSPE_INFO_SEGS 4
`define FSPE_MAIN_SEGS 8
// -----------------------------------------------------------------
// Commands
// -----------------------------------------------------------------
`define FSPE_CMD_READ 3'h0
`define FSPE_CMD_PROG_BYTE 3'h1
`define FSPE_CMD_PROG_WORD 3'h2
`define FSPE_CMD_SEG_ERASE 3'h3
`define FSPE_CMD_MAIN_ERASE 3'h4
`define FSPE_CMD_GROUP_ERASE 3'h5
// -----------------------------------------------------------------
// Request sources
// -----------------------------------------------------------------
`define FSPE_SRC_CPU 2'h0
`define FSPE_SRC_DEBUG 2'h1
`define FSPE_SRC_BOOT 2'h2
// -----------------------------------------------------------------
// Margin read modes
// -----------------------------------------------------------------
`define FSPE_MARGIN_NONE 2'h0
`define FSPE_MARGIN_ZERO 2'h1
`define FSPE_MARGIN_ONE 2'h2
// -----------------------------------------------------------------
// Values
// -----------------------------------------------------------------
`define FSPE_ERASED_WORD 16'hFFFF
`endif

// >>> logic/fspe_mem.v
// Word memory for the flash array, registered read data
module fspe_mem #(
  parameter AW = 12
) (
  // Clock
  input wire clk,
  input wire ce,
  // Port
  input wire we,
  input wire [1:0] be,
  input wire [AW-1:0] addr,
  input wire [15:0] wdata,
  output reg [15:0] rdata
);
  reg [15:0] mem [0:(1<<AW)-1];

  always @(posedge clk) begin
    if (ce) begin
      if (we && be[0])
        mem[addr][7:0] <= wdata[7:0];
      if (we && be[1])
        mem[addr][15:8] <= wdata[15:8];
      rdata <= mem[addr];
    end
  end
endmodule // fspe_mem

// >>> logic/fspe_top.v
// Flash segment program and erase sequencer
`include "fspe_consts.vh"

// Functional notes
// - Requests from debug port, boot loader and processor are handled alike.
// - Single byte and single 16-bit word programming are supported.
// - Main segments are 512 bytes and segment erase clears one aligned one.
// - Information area has four separately erasable 64-byte segments A-D.
// - Main array erases whole at once or one segment at a time.
// - Info segments erase singly or together with all main in a group erase.
// - Segment A is locked after reset until software clears the lock.
// - Margin read modes test cells against tightened thresholds.
// - Illegal access during an operation sets a flag; an enable gates its irq.
module fspe_top #(
  parameter MAIN_SEGS = `FSPE_MAIN_SEGS
) (
  // Clock and reset
  input wire clk,
  input wire reset,
  input wire clk_en,
  // Request
  input wire req_valid,
  input wire [1:0] req_src,
  input wire [2:0] req_cmd,
  input wire req_info,
  input wire [15:0] req_addr,
  input wire [15:0] req_wdata,
  input wire [1:0] margin_mode,
  // Control
  input wire seg_a_unlock,
  input wire seg_a_lock,
  input wire access_violation_irq_enable,
  input wire violation_clear,
  // Answer
  output reg busy_q,
  output reg done_q,
  output reg refused_q,
  output reg rdata_valid_q,
  output reg [15:0] rdata_q,
  output reg margin_fail_q,
  output reg seg_a_locked_q,
  output reg flash_access_violation_flag_q,
  output reg irq_q
);
  // -----------------------------------------------------------------
  // Geometry
  // -----------------------------------------------------------------
  localparam MW = `FSPE_MAIN_SEG_BYTES / 2;
  localparam IW = `FSPE_INFO_SEG_BYTES / 2;
  localparam MAIN_WORDS = MAIN_SEGS * MW;
  localparam INFO_WORDS = `FSPE_INFO_SEGS * IW;
  localparam TOT = MAIN_WORDS + INFO_WORDS;
  localparam AW = 12;

  localparam S_IDLE = 2'h0;
  localparam S_RD = 2'h1;
  localparam S_ERASE = 2'h2;
  localparam S_PROG = 2'h3;

  // Linear word index of a request address
  function [AW-1:0] widx;
    input info;
    input [15:0] a;
    begin
      if (info)
        widx = MAIN_WORDS[AW-1:0] + {5'h0, a[7:1]};
      else
        widx = a[AW:1];
    end
  endfunction

  reg [1:0] st_q;
  reg [AW-1:0] ptr_q;
  reg [AW-1:0] end_q;
  reg [2:0] cmd_q;
  reg [1:0] be_q;
  reg [15:0] wd_q;
  reg [1:0] mm_q;
  reg mem_we;
  reg [1:0] mem_be;
  reg [15:0] mem_wd;
  wire [15:0] mem_rd;
  wire [AW-1:0] rq_idx = widx(req_info, req_addr);
  wire idx_ok = req_info ? (req_addr[15:8] == 8'h00)
                         : (req_addr[15:1] < MAIN_WORDS);
  wire hit_a = req_info && (req_addr[7:6] == 2'h0);
  wire is_prog = (req_cmd == `FSPE_CMD_PROG_BYTE) ||
                 (req_cmd == `FSPE_CMD_PROG_WORD);
  wire is_seg = (req_cmd == `FSPE_CMD_SEG_ERASE);
  // Group erase includes A, so a lock refuses it too
  wire locked_hit = seg_a_locked_q &&
    (((is_prog || is_seg) && hit_a) ||
     (req_cmd == `FSPE_CMD_GROUP_ERASE));

  fspe_mem #(.AW(AW)) u_mem (
    .clk(clk),
    .ce(clk_en),
    .we(mem_we),
    .be(mem_be),
    .addr(ptr_q),
    .wdata(mem_wd),
    .rdata(mem_rd)
  );

  // -----------------------------------------------------------------
  // Memory write port
  // -----------------------------------------------------------------
  always @* begin
    mem_we = 1'b0;
    mem_be = 2'h3;
    mem_wd = `FSPE_ERASED_WORD;
    if (st_q == S_ERASE) begin
      mem_we = 1'b1;
    end else if (st_q == S_PROG) begin
      mem_we = 1'b1;
      mem_be = be_q;
      mem_wd = mem_rd & wd_q;
    end
  end

  // -----------------------------------------------------------------
  // Sequencer
  // -----------------------------------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      st_q <= S_IDLE;
      ptr_q <= {AW{1'b0}};
      end_q <= {AW{1'b0}};
      cmd_q <= `FSPE_CMD_READ;
      be_q <= 2'h0;
      wd_q <= 16'h0000;
      mm_q <= `FSPE_MARGIN_NONE;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      refused_q <= 1'b0;
      rdata_valid_q <= 1'b0;
      rdata_q <= 16'h0000;
      margin_fail_q <= 1'b0;
      seg_a_locked_q <= 1'b1;
      flash_access_violation_flag_q <= 1'b0;
      irq_q <= 1'b0;
    end else if (clk_en) begin
      done_q <= 1'b0;
      refused_q <= 1'b0;
      rdata_valid_q <= 1'b0;
      irq_q <= flash_access_violation_flag_q &&
               access_violation_irq_enable;
      if (seg_a_lock)
        seg_a_locked_q <= 1'b1;
      else if (seg_a_unlock)
        seg_a_locked_q <= 1'b0;
      // Set wins over clear
      if (req_valid && busy_q)
        flash_access_violation_flag_q <= 1'b1;
      else if (violation_clear)
        flash_access_violation_flag_q <= 1'b0;
      case (st_q)
        S_IDLE: begin
          // Source not used; behaviour identical for all
          if (req_valid) begin
            if (!idx_ok || locked_hit) begin
              refused_q <= 1'b1;
            end else begin
              busy_q <= 1'b1;
              cmd_q <= req_cmd;
              mm_q <= margin_mode;
              wd_q <= req_wdata;
              ptr_q <= rq_idx;
              end_q <= rq_idx;
              be_q <= (req_cmd == `FSPE_CMD_PROG_BYTE) ?
                (req_addr[0] ? 2'h2 : 2'h1) : 2'h3;
              if (req_cmd == `FSPE_CMD_PROG_BYTE)
                wd_q <= req_addr[0] ? {req_wdata[7:0], 8'hFF}
                                    : {8'hFF, req_wdata[7:0]};
              case (req_cmd)
                `FSPE_CMD_SEG_ERASE: begin
                  st_q <= S_ERASE;
                  if (req_info) begin
                    ptr_q <= rq_idx & ~(IW[AW-1:0] - 1'b1);
                    end_q <= rq_idx | (IW[AW-1:0] - 1'b1);
                  end else begin
                    ptr_q <= rq_idx & ~(MW[AW-1:0] - 1'b1);
                    end_q <= rq_idx | (MW[AW-1:0] - 1'b1);
                  end
                end
                `FSPE_CMD_MAIN_ERASE: begin
                  st_q <= S_ERASE;
                  ptr_q <= {AW{1'b0}};
                  end_q <= MAIN_WORDS[AW-1:0] - 1'b1;
                end
                `FSPE_CMD_GROUP_ERASE: begin
                  st_q <= S_ERASE;
                  ptr_q <= {AW{1'b0}};
                  end_q <= TOT[AW-1:0] - 1'b1;
                end
                default: st_q <= S_RD;
              endcase
            end
          end
        end
        S_RD: begin
          // Wait one cycle for registered read data
          if (cmd_q == `FSPE_CMD_READ) begin
            if (be_q == 2'h3) begin
              be_q <= 2'h0;
            end else begin
              rdata_q <= mem_rd;
              rdata_valid_q <= 1'b1;
              // Margin zero: a weak zero flags; margin one: weak one
              case (mm_q)
                `FSPE_MARGIN_ZERO: margin_fail_q <= (mem_rd != 16'h0000) &&
                                   (mem_rd != `FSPE_ERASED_WORD);
                `FSPE_MARGIN_ONE: margin_fail_q <= (mem_rd == 16'h0000);
                default: margin_fail_q <= 1'b0;
              endcase
              busy_q <= 1'b0;
              done_q <= 1'b1;
              st_q <= S_IDLE;
            end
          end else begin
            st_q <= S_PROG;
          end
        end
        S_PROG: begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
          st_q <= S_IDLE;
        end
        S_ERASE: begin
          if (ptr_q == end_q) begin
            busy_q <= 1'b0;
            done_q <= 1'b1;
            st_q <= S_IDLE;
          end else begin
            ptr_q <= ptr_q + 1'b1;
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end
endmodule // fspe_top

// >>> test/fspe_cpu_model.sv
// Processor bus master model issuing sequencer requests
module fspe_cpu_model (
  // Clock and status
  input wire clk,
  input wire busy_q,
  // Request
  output logic req_valid = 1'b0,
  output logic [1:0] req_src = 2'h0,
  output logic [2:0] req_cmd = 3'h0,
  output logic req_info = 1'b0,
  output logic [15:0] req_addr = 16'h0000,
  output logic [15:0] req_wdata = 16'h0000,
  // Status
  output logic stuck = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  // Raw strobes ignore busy, used only to provoke a violation
  task issue(input [1:0] s, input [2:0] c, input i, input [15:0] a,
    input [15:0] d, input raw);
    int n;
    @(negedge clk);
    for (n = 0; busy_q && !raw && n < 2000; n++) @(negedge clk);
    // A busy line that never drops is reported to the bench
    if (n == 2000)
      stuck = 1'b1;
    req_valid = 1'b1;
    req_src = s;
    req_cmd = c;
    req_info = i;
    req_addr = a;
    req_wdata = d;
    @(negedge clk);
    req_valid = 1'b0;
    // Released address and data lines must not keep showing the last value
    req_addr = ~a;
    req_wdata = ~d;
  endtask
endmodule // fspe_cpu_model

// >>> test/fspe_top_bench.sv
// Self-checking bench for the flash sequencer
`include "fspe_consts.vh"
module fspe_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, reset = 1'b1, unlock = 1'b0, lock = 1'b0;
  logic irq_en = 1'b0, vclr = 1'b0, ref_q, req_valid, req_info;
  logic ce = 1'b1, stuck, val_q;
  logic busy_q, done_q, refused_q, rvalid, mfail, locked, flag, irq_q;
  logic [1:0] mmode = 2'h0, src = 2'h0, req_src;
  logic [2:0] req_cmd;
  logic [15:0] req_addr, req_wdata, rdata_q, got;
  int fail_count = 0, n_checks = 0;
  always #5 clk = ~clk;
  fspe_cpu_model cpu (.clk(clk), .busy_q(busy_q), .req_valid(req_valid),
    .req_src(req_src), .req_cmd(req_cmd), .req_info(req_info),
    .req_addr(req_addr), .req_wdata(req_wdata), .stuck(stuck));
  fspe_top #(.MAIN_SEGS(2)) uut (.clk(clk), .reset(reset), .clk_en(ce),
    .req_valid(req_valid), .req_src(req_src), .req_cmd(req_cmd),
    .req_info(req_info), .req_addr(req_addr), .req_wdata(req_wdata),
    .margin_mode(mmode), .seg_a_unlock(unlock), .seg_a_lock(lock),
    .access_violation_irq_enable(irq_en), .violation_clear(vclr),
    .busy_q(busy_q), .done_q(done_q), .refused_q(refused_q),
    .rdata_valid_q(rvalid), .rdata_q(rdata_q), .margin_fail_q(mfail),
    .seg_a_locked_q(locked), .flash_access_violation_flag_q(flag),
    .irq_q(irq_q));
  // ----
  // Shared tasks
  // ----
  task check(input string what, input [15:0] seen, input [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task wrap_up;
    $display("Checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task fin;
    int n;
    for (n = 0; !(done_q || refused_q); n++) begin
      if (n == 1000 || stuck) begin
        fail_count++;
        wrap_up;
      end
      @(negedge clk);
    end
    ref_q = refused_q;
    val_q = rvalid;
    got = rdata_q;
  endtask
  task op(input [2:0] c, input i, input [15:0] a, input [15:0] d);
    src = (src == 2'h2) ? 2'h0 : src + 2'h1;
    cpu.issue(src, c, i, a, d, 1'b0);
    fin;
  endtask
  // ----
  // Scenarios
  // ----
  task t_main;
    op(3'h3, 0, 16'h00FF, 0);
    op(3'h3, 0, 16'h0200, 0);
    op(3'h2, 0, 16'h0200, 16'h1234);
    op(3'h1, 0, 16'h0201, 16'h000F);
    op(3'h0, 0, 16'h0200, 0);
    check("byte over word", got, 16'h0234);
    check("read strobe", val_q, 1);
    op(3'h2, 0, 16'h01FE, 16'h0000);
    check("no strobe on program", val_q, 0);
    op(3'h3, 0, 16'h0100, 0);
    op(3'h0, 0, 16'h01FE, 0);
    check("erased segment", got, `FSPE_ERASED_WORD);
    op(3'h0, 0, 16'h0200, 0);
    check("neighbour segment", got, 16'h0234);
    op(3'h0, 0, 16'h0400, 0);
    check("past main end", ref_q, 1);
    $display("Test main segments done");
  endtask
  task t_info;
    op(3'h3, 1, 16'h0000, 0);
    check("locked A erase", ref_q, 1);
    op(3'h5, 0, 0, 0);
    check("locked group", ref_q, 1);
    op(3'h3, 1, 16'h0040, 0);
    op(3'h2, 1, 16'h0040, 16'h00FF);
    mmode = 2'h1;
    op(3'h0, 1, 16'h0040, 0);
    check("margin zero", mfail, 1);
    mmode = 2'h2;
    op(3'h0, 1, 16'h0040, 0);
    check("margin one", mfail, 0);
    check("info data", got, 16'h00FF);
    mmode = 2'h0;
    unlock = 1'b1;
    op(3'h2, 1, 16'h0000, 16'h5555);
    check("A program", ref_q, 0);
    check("unlocked", locked, 0);
    op(3'h2, 0, 16'h0000, 16'hAAAA);
    op(3'h5, 0, 0, 0);
    op(3'h0, 1, 16'h0000, 0);
    check("group A", got, `FSPE_ERASED_WORD);
    op(3'h0, 0, 16'h0000, 0);
    check("group main", got, `FSPE_ERASED_WORD);
    op(3'h2, 1, 16'h0040, 16'h1111);
    op(3'h2, 0, 16'h03FE, 0);
    op(3'h4, 0, 0, 0);
    op(3'h0, 0, 16'h03FE, 0);
    check("main erase", got, `FSPE_ERASED_WORD);
    op(3'h0, 1, 16'h0040, 0);
    check("info kept", got, 16'h1111);
    lock = 1'b1;
    @(negedge clk);
    check("relocked", locked, 1);
    $display("Test info segments done");
  endtask
  task t_viol;
    cpu.issue(src, 3'h3, 0, 16'h0000, 0, 1'b0);
    cpu.issue(src, 3'h0, 0, 16'h0000, 0, 1'b1);
    fin;
    check("violation", flag, 1);
    check("masked irq", irq_q, 0);
    irq_en = 1'b1;
    repeat (2) @(negedge clk);
    check("irq", irq_q, 1);
    vclr = 1'b1;
    @(negedge clk);
    vclr = 1'b0;
    @(negedge clk);
    check("cleared", {flag, irq_q}, 0);
    $display("Test violation done");
  endtask
  task t_freeze;
    // Lock input drops while the enable is low: state must hold
    ce = 1'b0;
    lock = 1'b0;
    repeat (3) @(negedge clk);
    check("frozen lock", locked, 1);
    ce = 1'b1;
    @(negedge clk);
    check("thawed lock", locked, 0);
    lock = 1'b1;
    @(negedge clk);
    check("lock again", locked, 1);
    $display("Test clock enable done");
  endtask
  initial begin
    repeat (4) @(negedge clk);
    reset = 1'b0;
    check("lock after reset", {locked, busy_q}, 16'h0002);
    t_main;
    t_info;
    t_viol;
    t_freeze;
    wrap_up;
  end
endmodule // fspe_top_bench

// >>> test/fspe_top_properties.sv
// Port-level assertions for the flash sequencer
module fspe_top_properties #(
  parameter MAIN_SEGS = 8
) (
  // Clock and reset
  input logic clk,
  input logic reset,
  input logic clk_en,
  // Request
  input logic req_valid,
  input logic [2:0] req_cmd,
  input logic req_info,
  input logic [15:0] req_addr,
  input logic access_violation_irq_enable,
  // Answer
  input logic busy_q,
  input logic done_q,
  input logic refused_q,
  input logic rdata_valid_q,
  input logic seg_a_locked_q,
  input logic flash_access_violation_flag_q,
  input logic irq_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  wire take = clk_en && req_valid && !busy_q;
  wire in_main = !req_info && req_addr < MAIN_SEGS * 512;
  wire at_a = req_info && req_addr[15:6] == 10'h000;
  a_read_time: assert property (take && req_cmd == 3'h0 && in_main
    |-> ##3 rdata_valid_q && done_q) else $error("Read answer late");
  a_prog_time: assert property (take && req_cmd == 3'h2 && in_main
    |-> ##3 done_q) else $error("Program answer late");
  a_seg_erase: assert property (take && req_cmd == 3'h3 && in_main
    |-> ##1 busy_q [*8] ##249 done_q) else $error("Segment erase time");
  a_info_erase: assert property (take && req_cmd == 3'h3 && req_info
    && req_addr[15:6] == 10'h001 |-> ##33 done_q)
    else $error("Info erase time");
  a_lock_refuse: assert property (take && seg_a_locked_q && at_a
    && req_cmd inside {3'h1, 3'h2, 3'h3} |=> refused_q)
    else $error("Locked segment touched");
  a_group_refuse: assert property (take && req_cmd == 3'h5
    && seg_a_locked_q |=> refused_q) else $error("Group erase not refused");
  a_viol_set: assert property (clk_en && req_valid && busy_q
    |=> flash_access_violation_flag_q) else $error("Violation not flagged");
  a_irq_follow: assert property (!$past(reset) && $past(clk_en)
    |-> irq_q ==
    $past(flash_access_violation_flag_q && access_violation_irq_enable))
    else $error("Interrupt does not follow flag");
  a_lock_reset: assert property ($past(reset) |-> seg_a_locked_q)
    else $error("Segment A unlocked after reset");
  c_group: cover property (take && req_cmd == 3'h5 && !seg_a_locked_q);
  c_refuse: cover property (refused_q);
  c_irq: cover property (irq_q);
endmodule // fspe_top_properties

bind fspe_top fspe_top_properties #(.MAIN_SEGS(MAIN_SEGS)) chk (
  .clk(clk), .reset(reset), .clk_en(clk_en), .req_valid(req_valid),
  .req_cmd(req_cmd), .req_info(req_info), .req_addr(req_addr),
  .access_violation_irq_enable(access_violation_irq_enable),
  .busy_q(busy_q), .done_q(done_q), .refused_q(refused_q),
  .rdata_valid_q(rdata_valid_q), .seg_a_locked_q(seg_a_locked_q),
  .flash_access_violation_flag_q(flash_access_violation_flag_q),
  .irq_q(irq_q));
